// ==== dv/sdcd_ctl_model.sv ====
// Memory controller model driving the decoder command pins
`timescale 1ns/1ns
module sdcd_ctl_model
(
   input wire logic clk,
   output logic chip_select_n,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_enable_n,
   output logic clock_enable_current,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [11:0] addr,
   output logic data_mask
);
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hF;
      clock_enable_current = 1'h1;
      {bank_select_high, bank_select_low} = 2'h0;
      addr = 12'h000;
      data_mask = 1'h1;
   end

   function automatic logic [3:0] enc(sdcd_pkg::sdcd_cmd_t c);
      case (c)
         sdcd_pkg::SDCD_CMD_NOP: enc = 4'h7;
         sdcd_pkg::SDCD_CMD_ACT: enc = 4'h3;
         sdcd_pkg::SDCD_CMD_PRE: enc = 4'h2;
         sdcd_pkg::SDCD_CMD_RD: enc = 4'h5;
         sdcd_pkg::SDCD_CMD_WR: enc = 4'h4;
         sdcd_pkg::SDCD_CMD_MRS: enc = 4'h0;
         sdcd_pkg::SDCD_CMD_REF: enc = 4'h1;
         sdcd_pkg::SDCD_CMD_BST: enc = 4'h6;
         default: enc = 4'hF;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic issue(sdcd_pkg::sdcd_cmd_t c, logic [1:0] b, logic [11:0] a, logic m);
      @(posedge clk);
      #2;
      {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = enc(c);
      {bank_select_high, bank_select_low} = b;
      addr = a;
      data_mask = m;
      @(posedge clk);
      #2;
      {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = enc(sdcd_pkg::SDCD_CMD_NOP);
      {bank_select_high, bank_select_low} = ~b;
      addr = ~a;
   endtask

   task automatic idle(logic desel);
      @(posedge clk);
      #2;
      {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} =
         desel ? enc(sdcd_pkg::SDCD_CMD_DESEL) : enc(sdcd_pkg::SDCD_CMD_NOP);
      @(posedge clk);
      #2;
   endtask

   task automatic set_cke(logic v);
      @(posedge clk);
      #2;
      clock_enable_current = v;
      @(posedge clk);
      #2;
   endtask
endmodule

// ==== dv/sdram_command_decode_tb_top.sv ====
// Self-checking bench for the SDRAM command decoder
`timescale 1ns/1ns
`include "sdcd_map.svh"
module sdram_command_decode_tb_top;
   logic clk;
   logic sys_rst;
   wire cs_n, ras_n, cas_n, we_n, cke, bs_lo, bs_hi, dqm;
   wire [`SDCD_ADDR_W-1:0] addr;
   logic [3:0] cmd_code;
   logic [3:0] bank_active;
   logic [11:0] mode_value;
   logic burst_busy, burst_write, suspended, powered_down, data_out_enable, data_write_strobe;
   int mismatches = 0;
   int n_checks = 0;

   sdcd_ctl_model u_ctl (.clk(clk), .chip_select_n(cs_n), .row_strobe_n(ras_n),
      .col_strobe_n(cas_n), .write_enable_n(we_n), .clock_enable_current(cke),
      .bank_select_low(bs_lo), .bank_select_high(bs_hi), .addr(addr), .data_mask(dqm));

   sdcd_decoder dut (.clk(clk), .sys_rst(sys_rst), .chip_select_n(cs_n), .row_strobe_n(ras_n),
      .col_strobe_n(cas_n), .write_enable_n(we_n), .clock_enable_current(cke),
      .bank_select_low(bs_lo), .bank_select_high(bs_hi), .addr(addr), .data_mask(dqm),
      .cmd_code(cmd_code), .bank_active(bank_active), .mode_value(mode_value),
      .burst_busy(burst_busy), .burst_write(burst_write), .suspended(suspended),
      .powered_down(powered_down), .data_out_enable(data_out_enable),
      .data_write_strobe(data_write_strobe));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(logic [11:0] seen, logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic ccmd(sdcd_pkg::sdcd_cmd_t c);
      chk({8'h00, cmd_code}, {8'h00, c});
   endtask

   // Pins reach outputs two edges after sampling
   task automatic settle;
      repeat (2) @(posedge clk);
      #5;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      ccmd(sdcd_pkg::SDCD_CMD_NOP);
      chk({bank_active, mode_value[7:0]}, 12'h000);
      chk({burst_busy, burst_write, suspended, powered_down}, 12'h000);
   endtask

   task automatic t_mode_bank;
      u_ctl.issue(sdcd_pkg::SDCD_CMD_MRS, 2'h0, 12'h230, 1'h0);
      settle;
      ccmd(sdcd_pkg::SDCD_CMD_MRS);
      chk(mode_value, 12'h230);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_ACT, 2'h1, 12'h0AB, 1'h0);
      settle;
      ccmd(sdcd_pkg::SDCD_CMD_ACT);
      chk({8'h00, bank_active}, 12'h002);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_ACT, 2'h2, 12'h0CD, 1'h0);
      settle;
      chk({8'h00, bank_active}, 12'h006);
   endtask

   task automatic t_access;
      u_ctl.issue(sdcd_pkg::SDCD_CMD_RD, 2'h1, 12'h010, 1'h0);
      settle;
      chk({burst_busy, burst_write, data_out_enable}, 12'h005);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_RD, 2'h1, 12'h011, 1'h1);
      settle;
      chk({11'h000, data_out_enable}, 12'h000);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_RD, 2'h0, 12'h012, 1'h0);
      settle;
      chk({11'h000, data_out_enable}, 12'h000);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_WR, 2'h2, 12'h013, 1'h0);
      settle;
      chk({burst_write, data_write_strobe}, 12'h003);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_WR, 2'h2, 12'h014, 1'h1);
      settle;
      chk({11'h000, data_write_strobe}, 12'h000);
   endtask

   task automatic t_close;
      u_ctl.issue(sdcd_pkg::SDCD_CMD_PRE, 2'h1, 12'h000, 1'h0);
      settle;
      chk({8'h00, bank_active}, 12'h004);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_PRE, 2'h0, 12'h400, 1'h0);
      settle;
      chk({8'h00, bank_active}, 12'h000);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_REF, 2'h0, 12'h000, 1'h0);
      settle;
      ccmd(sdcd_pkg::SDCD_CMD_REF);
   endtask

   task automatic t_pdown;
      u_ctl.idle(1'h1);
      settle;
      ccmd(sdcd_pkg::SDCD_CMD_DESEL);
      u_ctl.set_cke(1'h0);
      settle;
      chk({suspended, powered_down}, 12'h001);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_ACT, 2'h3, 12'h055, 1'h0);
      settle;
      chk({8'h00, bank_active}, 12'h000);
      u_ctl.idle(1'h1);
      u_ctl.set_cke(1'h1);
      settle;
      chk({suspended, powered_down}, 12'h000);
      u_ctl.idle(1'h0);
   endtask

   task automatic t_full_page;
      u_ctl.issue(sdcd_pkg::SDCD_CMD_MRS, 2'h0, 12'h007, 1'h0);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_ACT, 2'h0, 12'h100, 1'h0);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_RD, 2'h0, 12'h020, 1'h0);
      settle;
      repeat (8) @(posedge clk);
      #5;
      chk({burst_busy, data_out_enable}, 12'h003);
      u_ctl.set_cke(1'h0);
      settle;
      chk({suspended, powered_down, burst_busy}, 12'h005);
      u_ctl.set_cke(1'h1);
      settle;
      chk({suspended, burst_busy}, 12'h001);
      u_ctl.issue(sdcd_pkg::SDCD_CMD_BST, 2'h0, 12'h000, 1'h0);
      settle;
      chk({burst_busy, bank_active}, 12'h001);
      u_ctl.set_cke(1'h0);
      settle;
      chk({suspended, powered_down}, 12'h001);
      u_ctl.set_cke(1'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst = 1'h1;
      repeat (4) @(posedge clk);
      #2;
      sys_rst = 1'h0;
      #5;
      t_reset;
      t_mode_bank;
      t_access;
      t_close;
      t_pdown;
      t_full_page;
      settle;
      end_sim;
   end

   initial
   begin
      #100000;
      mismatches++;
      end_sim;
   end
endmodule

// ==== inc/sdcd_map.svh ====
// Constants for the SDRAM command decoder
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH
`define SDCD_NUM_BANKS 4
`define SDCD_BANK_W 2
`define SDCD_ADDR_W 12
`define SDCD_AP_BIT 10
`define SDCD_BURST_W 10
`define SDCD_FULL_PAGE 10'h3FF
`define SDCD_BL_FIELD_LSB 0
`define SDCD_BL_FIELD_W 3
`define SDCD_BL_FULL 3'h7
`endif

// ==== inc/sdcd_pkg.sv ====
// Types for the SDRAM command decoder
package sdcd_pkg;
   typedef enum logic [3:0]
   {
      SDCD_CMD_DESEL = 4'h0,
      SDCD_CMD_NOP = 4'h1,
      SDCD_CMD_ACT = 4'h2,
      SDCD_CMD_PRE = 4'h3,
      SDCD_CMD_RD = 4'h4,
      SDCD_CMD_WR = 4'h5,
      SDCD_CMD_MRS = 4'h6,
      SDCD_CMD_REF = 4'h7,
      SDCD_CMD_BST = 4'h8
   } sdcd_cmd_t;

   typedef enum logic [1:0]
   {
      SDCD_ST_RUN = 2'h0,
      SDCD_ST_SUSPEND = 2'h1,
      SDCD_ST_PDOWN = 2'h2
   } sdcd_state_t;
endpackage

// ==== rtl/sdcd_decoder.sv ====
// SDRAM command decoder with clock-enable state logic
//
// Notes on behaviour
// - Commands, address and bank captured only on rising clock edges.
// - Decode uses previous and current clock enable levels together.
// - Bank commands act only on the bank selected by bank bits, except precharge with address bit 10 set, which closes all banks.
// - Power-down never entered while a burst runs.
// - Power-down request during a burst enters clock suspend instead.
// - Clock suspend entered on enable high-then-low during a burst, inputs ignored; with banks active and no burst, only when selected with a strobe low.
// - Clock suspend left on enable low-then-high, whatever the command.
// - Power-down entered on enable falling with deselect or strobes high while idle or active, no burst.
// - Power-down left on enable rising with deselect or select plus strobes high.
// - Mode register set: all four low; address holds the value.
// - Burst read: select and column low, row and write high.
// - Burst write: select, column, write low, row high; data same cycle.
// - Burst stop: select and write low, both strobes high.
`timescale 1ns/1ns
`include "sdcd_map.svh"
module sdcd_decoder #(
   parameter int BURST_W = `SDCD_BURST_W
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_enable_n,
   input wire logic clock_enable_current,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [`SDCD_ADDR_W-1:0] addr,
   input wire logic data_mask,
   output logic [3:0] cmd_code,
   output logic [`SDCD_NUM_BANKS-1:0] bank_active,
   output logic [`SDCD_ADDR_W-1:0] mode_value,
   output logic burst_busy,
   output logic burst_write,
   output logic suspended,
   output logic powered_down,
   output logic data_out_enable,
   output logic data_write_strobe
);
   localparam logic [BURST_W-1:0] FULL_PAGE = BURST_W'(`SDCD_FULL_PAGE);

   logic [`SDCD_ADDR_W+9-1:0] pins_raw;
   logic [`SDCD_ADDR_W+9-1:0] pins_s;
   logic cs_n, ras_n, cas_n, we_n, cke, dqm;
   logic [`SDCD_BANK_W-1:0] bank;
   logic [`SDCD_ADDR_W-1:0] a_in;

   assign pins_raw = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
                      clock_enable_current, data_mask, bank_select_high,
                      bank_select_low, 1'b0, addr};

   ////////////////////////////////////////////////////////////////////////
   // pins sampled on rising edges
   sdcd_sync #(.WIDTH(`SDCD_ADDR_W+9)) u_sync
   (
      .clk(clk),
      .din(pins_raw),
      .dout(pins_s)
   );

   assign {cs_n, ras_n, cas_n, we_n, cke, dqm} = pins_s[`SDCD_ADDR_W+8:`SDCD_ADDR_W+3];
   assign bank = pins_s[`SDCD_ADDR_W+2:`SDCD_ADDR_W+1];
   assign a_in = pins_s[`SDCD_ADDR_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   logic clock_enable_previous_reg, clock_enable_previous_next;
   sdcd_pkg::sdcd_state_t state_reg, state_next;
   sdcd_pkg::sdcd_cmd_t cmd_reg, cmd_next;
   logic [`SDCD_NUM_BANKS-1:0] bank_reg, bank_next;
   logic [`SDCD_ADDR_W-1:0] mode_reg, mode_next;
   logic [BURST_W-1:0] left_reg, left_next;
   logic busy_reg, busy_next;
   logic bwr_reg, bwr_next;
   logic oe_reg, oe_next;
   logic wstb_reg, wstb_next;
   logic [1:0] lvl_reg, lvl_next;
   logic [BURST_W-1:0] blen;
   logic cke_fall, cke_rise, any_active, strobes_high;
   sdcd_pkg::sdcd_cmd_t dec;

   // Burst length from mode value: 0..3 gives 1,2,4,8, full code gives page
   always_comb
   begin
      blen = '0;
      if (mode_reg[`SDCD_BL_FIELD_LSB +: `SDCD_BL_FIELD_W] == `SDCD_BL_FULL)
      begin
         blen = FULL_PAGE;
      end
      else
      begin
         blen = BURST_W'((1 << mode_reg[`SDCD_BL_FIELD_LSB +: 2]) - 1);
      end
   end

   // edge of enable across two cycles
   assign cke_fall = clock_enable_previous_reg && !cke;
   assign cke_rise = !clock_enable_previous_reg && cke;
   assign any_active = |bank_reg;
   assign strobes_high = ras_n && cas_n;

   always_comb
   begin
      dec = sdcd_pkg::SDCD_CMD_DESEL;
      if (!cs_n)
      begin
         case ({ras_n, cas_n, we_n})
            3'h7: dec = sdcd_pkg::SDCD_CMD_NOP;
            3'h3: dec = sdcd_pkg::SDCD_CMD_ACT;
            3'h2: dec = sdcd_pkg::SDCD_CMD_PRE;
            3'h5: dec = sdcd_pkg::SDCD_CMD_RD;
            3'h4: dec = sdcd_pkg::SDCD_CMD_WR;
            3'h0: dec = sdcd_pkg::SDCD_CMD_MRS;
            3'h1: dec = sdcd_pkg::SDCD_CMD_REF;
            3'h6: dec = sdcd_pkg::SDCD_CMD_BST;
            default: dec = sdcd_pkg::SDCD_CMD_NOP;
         endcase
      end
   end

   always_comb
   begin
      clock_enable_previous_next = cke;
      state_next = state_reg;
      cmd_next = sdcd_pkg::SDCD_CMD_NOP;
      bank_next = bank_reg;
      mode_next = mode_reg;
      left_next = left_reg;
      busy_next = busy_reg;
      bwr_next = bwr_reg;
      oe_next = 1'b0;
      wstb_next = 1'b0;
      case (state_reg)
         sdcd_pkg::SDCD_ST_RUN:
         begin
            if (cke_fall)
            begin
               // suspend during a burst, other inputs ignored
               if (busy_reg)
               begin
                  state_next = sdcd_pkg::SDCD_ST_SUSPEND;
               end
               // power-down needs deselect or strobes high
               else if (cs_n || strobes_high)
               begin
                  state_next = sdcd_pkg::SDCD_ST_PDOWN;
               end
               else if (any_active)
               begin
                  state_next = sdcd_pkg::SDCD_ST_SUSPEND;
               end
            end
            else if (clock_enable_previous_reg)
            begin
               cmd_next = dec;
               if (busy_reg)
               begin
                  if (left_reg == '0)
                  begin
                     busy_next = 1'b0;
                  end
                  else
                  begin
                     oe_next = !bwr_reg && !dqm;
                     wstb_next = bwr_reg && !dqm;
                     left_next = (blen == FULL_PAGE) ? left_reg : left_reg - 1'b1;
                  end
               end
               case (dec)
                  sdcd_pkg::SDCD_CMD_ACT: bank_next[bank] = 1'b1;
                  sdcd_pkg::SDCD_CMD_PRE:
                  begin
                     if (a_in[`SDCD_AP_BIT])
                     begin
                        bank_next = '0;
                     end
                     else
                     begin
                        bank_next[bank] = 1'b0;
                     end
                  end
                  sdcd_pkg::SDCD_CMD_RD, sdcd_pkg::SDCD_CMD_WR:
                  begin
                     if (bank_reg[bank])
                     begin
                        busy_next = 1'b1;
                        bwr_next = (dec == sdcd_pkg::SDCD_CMD_WR);
                        left_next = blen;
                        oe_next = (dec == sdcd_pkg::SDCD_CMD_RD) && !dqm;
                        // first word taken with the command
                        wstb_next = (dec == sdcd_pkg::SDCD_CMD_WR) && !dqm;
                     end
                  end
                  sdcd_pkg::SDCD_CMD_MRS:
                  begin
                     if (!any_active)
                     begin
                        mode_next = a_in;
                     end
                  end
                  // stop ends any burst, full page or not
                  sdcd_pkg::SDCD_CMD_BST: busy_next = 1'b0;
                  default: ;
               endcase
            end
         end
         sdcd_pkg::SDCD_ST_SUSPEND:
         begin
            if (cke_rise)
            begin
               state_next = sdcd_pkg::SDCD_ST_RUN;
            end
         end
         sdcd_pkg::SDCD_ST_PDOWN:
         begin
            // exit with deselect or strobes high
            if (cke_rise && (cs_n || strobes_high))
            begin
               state_next = sdcd_pkg::SDCD_ST_RUN;
            end
         end
         default: state_next = sdcd_pkg::SDCD_ST_RUN;
      endcase
      if (sys_rst)
      begin
         state_next = sdcd_pkg::SDCD_ST_RUN;
         cmd_next = sdcd_pkg::SDCD_CMD_NOP;
         bank_next = '0;
         mode_next = '0;
         left_next = '0;
         busy_next = 1'b0;
         bwr_next = 1'b0;
         oe_next = 1'b0;
         wstb_next = 1'b0;
         clock_enable_previous_next = 1'b1;
      end
      lvl_next = {state_next == sdcd_pkg::SDCD_ST_SUSPEND,
                  state_next == sdcd_pkg::SDCD_ST_PDOWN};
   end

   always_ff @(posedge clk)
   begin
      clock_enable_previous_reg <= clock_enable_previous_next;
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      bank_reg <= bank_next;
      mode_reg <= mode_next;
      left_reg <= left_next;
      busy_reg <= busy_next;
      bwr_reg <= bwr_next;
      oe_reg <= oe_next;
      wstb_reg <= wstb_next;
      lvl_reg <= lvl_next;
   end

   assign cmd_code = cmd_reg;
   assign bank_active = bank_reg;
   assign mode_value = mode_reg;
   assign burst_busy = busy_reg;
   assign burst_write = bwr_reg;
   assign suspended = lvl_reg[1];
   assign powered_down = lvl_reg[0];
   assign data_out_enable = oe_reg;
   assign data_write_strobe = wstb_reg;

   ////////////////////////////////////////////////////////////////////////
   sequence s_fall_in_burst;
      busy_reg && (state_reg == sdcd_pkg::SDCD_ST_RUN) && cke_fall;
   endsequence

   AST_NO_PD_IN_BURST: assert property (@(posedge clk) disable iff (sys_rst)
      s_fall_in_burst |=> !powered_down)
      else $error("power-down entered during burst");
   AST_SUSPEND_IN_BURST: assert property (@(posedge clk) disable iff (sys_rst)
      s_fall_in_burst |=> suspended && burst_busy)
      else $error("burst not frozen in suspend");
   AST_SUSPEND_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      suspended && !cke_rise |=> suspended && $stable(bank_active))
      else $error("suspend state changed without enable rise");
   AST_SUSPEND_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
      suspended && cke_rise |=> !suspended)
      else $error("suspend not left");
   AST_PD_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == sdcd_pkg::SDCD_ST_RUN) && cke_fall && !busy_reg && cs_n |=> powered_down)
      else $error("power-down not entered");
   AST_PD_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
      powered_down && cke_rise && cs_n |=> !powered_down)
      else $error("power-down not left");
   AST_ACT_BANK: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == sdcd_pkg::SDCD_ST_RUN) && clock_enable_previous_reg && cke
      && dec == sdcd_pkg::SDCD_CMD_ACT |=> bank_active[$past(bank)])
      else $error("activate missed bank");
   AST_PREALL: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == sdcd_pkg::SDCD_ST_RUN) && clock_enable_previous_reg && !cke_fall
      && dec == sdcd_pkg::SDCD_CMD_PRE && a_in[`SDCD_AP_BIT] |=> bank_active == '0)
      else $error("precharge all left banks open");
   AST_MASK: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(data_out_enable) || $rose(data_write_strobe) |-> !$past(dqm))
      else $error("data path active under mask");
endmodule

// ==== rtl/sdcd_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sdcd_sync #(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] dout_reg;
   logic [WIDTH-1:0] dout_next;

   always_comb
   begin
      meta_next = din;
      dout_next = meta_reg;
   end

   always_ff @(posedge clk)
   begin
      meta_reg <= meta_next;
      dout_reg <= dout_next;
   end

   assign dout = dout_reg;
endmodule
